/* File: pkg/aicc_pkg.sv */
// constants for the converter input, reference and clock configuration block
// Operation
// - bandgap input select at 1 routes the internal 1.19V bandgap to converter input
// - while bandgap is selected every external analog channel is disconnected
// - bandgap powers off when unused by converter and low-voltage monitor is off
// - reference select 1 picks the external reference pin, 0 the supply
// - divider codes 000, 001, 010 give system clock, half and quarter
// - unimplemented bits of control and pin enable registers read zero
// - pin enable 1 makes the pin an analog channel, 0 keeps other function
// - enables 0-7 map port a pins 0-7, enables 8-11 port h pins 0-3
// - codes 011 to 110 divide by 8, 16, 32, 64; code 111 undefined
// - analog pin loses its pull-up and its direction control is overridden
// - external reference selected gives the shared pin to the reference only
package aicc_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [11:0] OFF_CTRL_ONE   = 12'h000;
	localparam logic [11:0] OFF_PIN_EN_LO  = 12'h004;
	localparam logic [11:0] OFF_PIN_EN_HI  = 12'h008;
	localparam logic [11:0] OFF_STATUS     = 12'h00c;

	// ==========================================================
	// control register fields
	localparam int          BIT_BG_INPUT_SEL = 7;
	localparam int          BIT_BG_ENABLE    = 6;
	localparam int          BIT_REF_SEL      = 4;
	localparam int          DIV_LSB          = 0;
	localparam logic [7:0]  CTRL_IMPL_MASK   = 8'hd7;
	localparam logic [7:0]  CTRL_RESET       = 8'h00;

	// ==========================================================
	// pin enable registers
	localparam int          NUM_PINS         = 12;
	localparam int          NUM_PORT_A       = 8;
	localparam logic [7:0]  PIN_LO_MASK      = 8'hff;
	localparam logic [7:0]  PIN_HI_MASK      = 8'h0f;
	localparam logic [7:0]  PIN_LO_RESET     = 8'hff;
	localparam logic [7:0]  PIN_HI_RESET     = 8'h0f;

	// ==========================================================
	// status register fields
	localparam int          ST_BG_POWER      = 0;
	localparam int          ST_REF_EXT       = 1;
	localparam int          ST_BG_ROUTED     = 2;
	localparam int          ST_MONITOR       = 3;

	// ==========================================================
	// converter clock divider
	localparam int          DIV_CNT_W        = 6;
	localparam logic [2:0]  DIV_UNDEFINED    = 3'h7;
	localparam logic [5:0]  DIV_CNT_RESET    = 6'h00;

endpackage

/* File: pkg/aicc_div_if.sv */
// link between the control registers and the converter clock divider
interface aicc_div_if;
	logic [2:0] code;
	logic       tick;

	modport ctl (
		output code,
		input  tick
	);

	modport div (
		input  code,
		output tick
	);
endinterface

/* File: logic/aicc_clkdiv.sv */
// converter clock enable divider from the system clock
module aicc_clkdiv (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// divider link
	aicc_div_if.div   link
);

	// ==========================================================
	// free running count, terminal value chosen by code
	logic [aicc_pkg::DIV_CNT_W-1:0] cnt_reg;
	logic [aicc_pkg::DIV_CNT_W-1:0] cnt_next;
	logic [aicc_pkg::DIV_CNT_W-1:0] term;
	logic                           hit;
	logic                           tick_reg;
	logic                           tick_next;

	// terminal = 2^code - 1; code 111 stops the clock rather than guessing a rate
	assign term      = aicc_pkg::DIV_CNT_W'((7'h01 << link.code) - 7'h01);
	assign hit       = (cnt_reg >= term);
	assign cnt_next  = hit ? aicc_pkg::DIV_CNT_RESET : cnt_reg + 6'h01;
	assign tick_next = hit && (link.code != aicc_pkg::DIV_UNDEFINED);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg  <= aicc_pkg::DIV_CNT_RESET;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign link.tick = tick_reg;

endmodule

/* File: logic/aicc_top.sv */
// converter input, reference and clock configuration with apb registers
//
// Implementation choices: the address map and the APB interface to the registers.
module aicc_top (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// converter core
	input  wire logic [3:0]  conv_channel_sel,
	output logic             conv_clk_en,
	output logic             conv_in_bandgap,
	output logic      [11:0] conv_chan_connect,
	output logic             conv_ref_ext,
	// bandgap and low-voltage monitor
	input  wire logic        low_voltage_monitor_en,
	output logic             bandgap_power,
	// port pin requests from the general purpose io logic
	input  wire logic [7:0]  port_a_direction_control,
	input  wire logic [3:0]  port_h_direction_control,
	input  wire logic [11:0] pin_pullup_req,
	input  wire logic        ref_pin_other_req,
	// port pin controls after the analog override
	output logic      [11:0] pin_analog_en,
	output logic      [11:0] pin_input_dir,
	output logic      [11:0] pin_pullup_en,
	output logic      [11:0] pin_other_func_en,
	output logic             ref_pin_ref_en,
	output logic             ref_pin_other_en
);

	// ==========================================================
	// address decode
	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
		addr_is = (a == off);
	endfunction

	logic        sel_ctrl;
	logic        sel_lo;
	logic        sel_hi;
	logic        sel_st;
	logic        mapped;
	logic        setup_ph;
	logic        access_ph;
	logic        wr_lane0;

	assign sel_ctrl  = addr_is(paddr, aicc_pkg::OFF_CTRL_ONE);
	assign sel_lo    = addr_is(paddr, aicc_pkg::OFF_PIN_EN_LO);
	assign sel_hi    = addr_is(paddr, aicc_pkg::OFF_PIN_EN_HI);
	assign sel_st    = addr_is(paddr, aicc_pkg::OFF_STATUS);
	assign mapped    = sel_ctrl | sel_lo | sel_hi | sel_st;
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	// status is read only, so a write to it is ignored without an error
	assign wr_lane0  = access_ph & pwrite & pstrb[0];

	// zero wait states; every access completes in its first access cycle
	assign pready    = 1'b1;
	assign pslverr   = access_ph & ~mapped;

	// ==========================================================
	// registers
	logic [7:0]  ctrl_reg;
	logic [7:0]  ctrl_next;
	logic [7:0]  pin_lo_reg;
	logic [7:0]  pin_lo_next;
	logic [7:0]  pin_hi_reg;
	logic [7:0]  pin_hi_next;

	// unimplemented positions are masked on write so they always read zero
	assign ctrl_next   = (wr_lane0 & sel_ctrl) ?
		(pwdata[7:0] & aicc_pkg::CTRL_IMPL_MASK) : ctrl_reg;
	assign pin_lo_next = (wr_lane0 & sel_lo) ?
		(pwdata[7:0] & aicc_pkg::PIN_LO_MASK) : pin_lo_reg;
	assign pin_hi_next = (wr_lane0 & sel_hi) ?
		(pwdata[7:0] & aicc_pkg::PIN_HI_MASK) : pin_hi_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= aicc_pkg::CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_lo_reg <= aicc_pkg::PIN_LO_RESET;
		end else begin
			pin_lo_reg <= pin_lo_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_hi_reg <= aicc_pkg::PIN_HI_RESET;
		end else begin
			pin_hi_reg <= pin_hi_next;
		end
	end

	// ==========================================================
	// control fields
	logic        bandgap_input_select;
	logic        bandgap_enable;
	logic        reference_source_select;
	logic [2:0]  converter_clock_divider;
	logic [11:0] analog_pin_enable;

	assign bandgap_input_select    = ctrl_reg[aicc_pkg::BIT_BG_INPUT_SEL];
	assign bandgap_enable          = ctrl_reg[aicc_pkg::BIT_BG_ENABLE];
	assign reference_source_select = ctrl_reg[aicc_pkg::BIT_REF_SEL];
	assign converter_clock_divider = ctrl_reg[aicc_pkg::DIV_LSB +: 3];
	// low register holds port a, high register port h
	assign analog_pin_enable       = {pin_hi_reg[3:0], pin_lo_reg};

	// ==========================================================
	// converter clock divider
	aicc_div_if div_link ();

	assign div_link.code = converter_clock_divider;

	aicc_clkdiv u_clkdiv (
		.pclk    (pclk),
		.presetn (presetn),
		.link    (div_link)
	);

	// tick is already a flop output inside the divider
	assign conv_clk_en = div_link.tick;

	// ==========================================================
	// bandgap and reference
	logic        bg_power_next;
	logic        bg_route_next;
	logic        ref_ext_next;
	logic        bg_power_reg;
	logic        bg_route_reg;
	logic        ref_ext_reg;

	// the bandgap also serves the low-voltage monitor, so either keeps it on
	assign bg_power_next = bandgap_enable | low_voltage_monitor_en;
	// routing does not wait for the enable; software is trusted to order them
	assign bg_route_next = bandgap_input_select;
	assign ref_ext_next  = reference_source_select;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bg_power_reg <= 1'b0;
		end else begin
			bg_power_reg <= bg_power_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bg_route_reg <= 1'b0;
		end else begin
			bg_route_reg <= bg_route_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_ext_reg <= 1'b0;
		end else begin
			ref_ext_reg <= ref_ext_next;
		end
	end

	assign bandgap_power   = bg_power_reg;
	assign conv_in_bandgap = bg_route_reg;
	assign conv_ref_ext    = ref_ext_reg;

	// ==========================================================
	// reference pin sharing
	logic        ref_pin_ref_reg;
	logic        ref_pin_other_reg;
	logic        ref_pin_other_next;

	assign ref_pin_other_next = ref_pin_other_req & ~reference_source_select;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_pin_ref_reg   <= 1'b0;
			ref_pin_other_reg <= 1'b0;
		end else begin
			ref_pin_ref_reg   <= reference_source_select;
			ref_pin_other_reg <= ref_pin_other_next;
		end
	end

	assign ref_pin_ref_en   = ref_pin_ref_reg;
	assign ref_pin_other_en = ref_pin_other_reg;

	// ==========================================================
	// shared analog pins
	logic [11:0] dir_ctl;
	logic [11:0] analog_next;
	logic [11:0] input_dir_next;
	logic [11:0] pullup_next;
	logic [11:0] other_next;
	logic [11:0] connect_next;
	logic [11:0] analog_reg;
	logic [11:0] input_dir_reg;
	logic [11:0] pullup_reg;
	logic [11:0] other_reg;
	logic [11:0] connect_reg;

	assign dir_ctl = {port_h_direction_control, port_a_direction_control};

	genvar gi;
	generate
		for (gi = 0; gi < aicc_pkg::NUM_PINS; gi++) begin : g_pin
			// enable bit gi serves analog channel gi
			assign analog_next[gi]    = analog_pin_enable[gi];
			// an analog pin is forced to input whatever the direction control says
			assign input_dir_next[gi] = analog_pin_enable[gi] | dir_ctl[gi];
			assign pullup_next[gi]    = pin_pullup_req[gi] & ~analog_pin_enable[gi];
			assign other_next[gi]     = ~analog_pin_enable[gi];
			// a channel switch closes only when enabled, selected and bandgap not routed
			assign connect_next[gi]   = analog_pin_enable[gi] & ~bandgap_input_select &
				(conv_channel_sel == 4'(gi));
		end
	endgenerate

	// analog and direction flops start from the enable reset values so pins are analog out of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_reg <= {aicc_pkg::PIN_HI_RESET[3:0], aicc_pkg::PIN_LO_RESET};
		end else begin
			analog_reg <= analog_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_dir_reg <= {aicc_pkg::PIN_HI_RESET[3:0], aicc_pkg::PIN_LO_RESET};
		end else begin
			input_dir_reg <= input_dir_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_reg <= 12'h000;
		end else begin
			pullup_reg <= pullup_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			other_reg <= 12'h000;
		end else begin
			other_reg <= other_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			connect_reg <= 12'h000;
		end else begin
			connect_reg <= connect_next;
		end
	end

	assign pin_analog_en     = analog_reg;
	assign pin_input_dir     = input_dir_reg;
	assign pin_pullup_en     = pullup_reg;
	assign pin_other_func_en = other_reg;
	assign conv_chan_connect = connect_reg;

	// ==========================================================
	// status and read path
	logic [7:0]  status_val;
	logic [7:0]  rd_byte;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;

	assign status_val = {4'h0, low_voltage_monitor_en, bg_route_reg,
		ref_ext_reg, bg_power_reg};

	// read data is captured in the setup cycle so it stands through the access
	assign rd_byte = sel_ctrl ? (ctrl_reg & aicc_pkg::CTRL_IMPL_MASK) :
		sel_lo ? pin_lo_reg :
		sel_hi ? (pin_hi_reg & aicc_pkg::PIN_HI_MASK) :
		sel_st ? status_val : 8'h00;

	assign prdata_next = (setup_ph & ~pwrite) ? {24'h000000, rd_byte} : prdata_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	assign prdata = prdata_reg;

endmodule

/* File: tb/aicc_top_props.sv */
// port relation checker for the converter configuration block
module aicc_top_props (
	// clock, reset and apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	// converter side
	input wire logic [3:0]  conv_channel_sel,
	input wire logic        conv_in_bandgap,
	input wire logic [11:0] conv_chan_connect,
	input wire logic        conv_ref_ext,
	input wire logic        low_voltage_monitor_en,
	input wire logic        bandgap_power,
	// pin side
	input wire logic [7:0]  port_a_direction_control,
	input wire logic [3:0]  port_h_direction_control,
	input wire logic [11:0] pin_pullup_req,
	input wire logic        ref_pin_other_req,
	input wire logic [11:0] pin_analog_en,
	input wire logic [11:0] pin_input_dir,
	input wire logic [11:0] pin_pullup_en,
	input wire logic [11:0] pin_other_func_en,
	input wire logic        ref_pin_ref_en,
	input wire logic        ref_pin_other_en
);
	timeunit 1ns;
	timeprecision 1ps;
	// =============================================
	// qualifier
	// past values are stale on the first edge after reset, so wait one edge
	logic live;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			live <= 1'b0;
		else
			live <= 1'b1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn || !live);
	// =============================================
	// properties
	a_pullup_drop: assert property (
		pin_pullup_en == ($past(pin_pullup_req) & ~pin_analog_en))
		else $error("pull-up left on analog pin");
	a_dir_override: assert property (pin_input_dir == (pin_analog_en |
		$past({port_h_direction_control, port_a_direction_control}))) else $error("dir wrong");
	a_other_func: assert property (pin_other_func_en == ~pin_analog_en)
		else $error("other function not exclusive");
	a_bg_isolate: assert property (conv_in_bandgap |-> conv_chan_connect == 12'h000)
		else $error("channel connected while bandgap routed");
	a_chan_map: assert property (conv_chan_connect != 12'h000 |-> conv_chan_connect ==
		((12'h001 << $past(conv_channel_sel)) & pin_analog_en)) else $error("channel map wrong");
	a_ref_pin: assert property (
		ref_pin_other_en == ($past(ref_pin_other_req) & ~ref_pin_ref_en))
		else $error("reference pin shared");
	a_ref_src: assert property (conv_ref_ext == ref_pin_ref_en)
		else $error("reference source mismatch");
	a_monitor_power: assert property ($past(low_voltage_monitor_en) |-> bandgap_power)
		else $error("bandgap off while monitor on");
	a_read_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule

/* File: tb/aicc_core_model.sv */
// converter core stand-in that scans channels on the converter clock
module aicc_core_model (
	// clock and reset
	input wire logic         pclk,
	input wire logic         presetn,
	// converter link
	input wire logic         conv_clk_en,
	output logic      [3:0]  conv_channel_sel,
	output logic      [15:0] pulses
);
	timeunit 1ns;
	timeprecision 1ps;
	// the channel moves only on a converter clock, as a real scan would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_channel_sel <= 4'h0;
			pulses <= 16'h0000;
		end else if (conv_clk_en) begin
			conv_channel_sel <= (conv_channel_sel == 4'hb) ? 4'h0 : conv_channel_sel + 4'h1;
			pulses <= pulses + 16'h0001;
		end
	end
endmodule

/* File: tb/aicc_top_test.sv */
// self-checking bench of the converter configuration block
module aicc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, low_voltage_monitor_en, ref_pin_other_req;
	logic pready, pslverr, conv_clk_en, conv_in_bandgap, conv_ref_ext, bandgap_power;
	logic ref_pin_ref_en, ref_pin_other_en;
	logic [3:0] pstrb, conv_channel_sel, port_h_direction_control;
	logic [7:0] port_a_direction_control;
	logic [11:0] paddr, pin_pullup_req, conv_chan_connect, pin_analog_en;
	logic [11:0] pin_input_dir, pin_pullup_en, pin_other_func_en;
	logic [31:0] pwdata, prdata;
	logic [15:0] pulses;
	logic [32:0] expq[$];
	int n_fail, checks;

	aicc_top u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_channel_sel(conv_channel_sel), .conv_clk_en(conv_clk_en),
		.conv_in_bandgap(conv_in_bandgap), .conv_chan_connect(conv_chan_connect),
		.conv_ref_ext(conv_ref_ext), .low_voltage_monitor_en(low_voltage_monitor_en),
		.bandgap_power(bandgap_power), .port_a_direction_control(port_a_direction_control),
		.port_h_direction_control(port_h_direction_control), .pin_pullup_req(pin_pullup_req),
		.ref_pin_other_req(ref_pin_other_req), .pin_analog_en(pin_analog_en),
		.pin_input_dir(pin_input_dir), .pin_pullup_en(pin_pullup_en),
		.pin_other_func_en(pin_other_func_en), .ref_pin_ref_en(ref_pin_ref_en),
		.ref_pin_other_en(ref_pin_other_en));
	aicc_core_model u_core (.pclk(pclk), .presetn(presetn), .conv_clk_en(conv_clk_en),
		.conv_channel_sel(conv_channel_sel), .pulses(pulses));

	always #12.5 pclk = ~pclk;

	// =============================================
	// random pin requests every cycle
	always @(posedge pclk) begin
		port_a_direction_control <= 8'($urandom);
		port_h_direction_control <= 4'($urandom);
		pin_pullup_req <= 12'($urandom);
		ref_pin_other_req <= 1'($urandom);
	end

	// =============================================
	// tasks
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 20) begin
			n_fail++;
			close_out();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		expq.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask

	// read answers are matched against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && expq.size() > 0)
			chk({pslverr, prdata}, expq.pop_front());
	end

	initial begin
		#500000;
		n_fail++;
		close_out();
	end

	// =============================================
	// main sequence
	initial begin
		logic [15:0] p0;
		logic [11:0] v;
		{pclk, presetn, psel, penable, pwrite, low_voltage_monitor_en} = 6'h00;
		{ref_pin_other_req, paddr, pwdata, pin_pullup_req} = '0;
		{port_a_direction_control, port_h_direction_control} = 12'h000;
		pstrb = 4'h1;
		void'($urandom(32'h20df));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, 33'h000);
		rd(12'h004, 33'h0ff);
		rd(12'h008, 33'h00f);
		chk(pin_analog_en, 33'hfff);
		xfer(1'b1, 12'h000, 32'hffffffff);
		rd(12'h000, 33'h0d7);
		xfer(1'b1, 12'h008, 32'hffffffff);
		rd(12'h008, 33'h00f);
		rd(12'h010, {1'b1, 32'h0});
		// bandgap enable goes first so the reference runs when routed
		xfer(1'b1, 12'h000, 32'h40);
		xfer(1'b1, 12'h000, 32'hc0);
		cyc(3);
		chk(conv_in_bandgap, 33'h1);
		chk(conv_chan_connect, 33'h0);
		chk(bandgap_power, 33'h1);
		xfer(1'b1, 12'h000, 32'h10);
		cyc(3);
		chk(bandgap_power, 33'h0);
		chk({conv_ref_ext, ref_pin_ref_en}, 33'h3);
		low_voltage_monitor_en <= 1'b1;
		cyc(3);
		chk(bandgap_power, 33'h1);
		// status: monitor on, bandgap not routed, external reference, bandgap powered
		rd(12'h00c, 33'h00b);
		low_voltage_monitor_en <= 1'b0;
		for (int code = 0; code < 8; code++) begin
			xfer(1'b1, 12'h000, 32'(code));
			cyc(70);
			p0 = pulses;
			cyc(128);
			chk(pulses - p0, (code == 7) ? 33'h0 : 33'(128 >> code));
		end
		xfer(1'b1, 12'h000, 32'h0);
		// a write without the low byte strobe must leave the register alone
		pstrb <= 4'he;
		xfer(1'b1, 12'h000, 32'h000000ff);
		pstrb <= 4'h1;
		rd(12'h000, 33'h000);
		for (int i = 0; i < 6; i++) begin
			v = 12'($urandom);
			xfer(1'b1, 12'h004, {24'h0, v[7:0]});
			xfer(1'b1, 12'h008, {28'h0, v[11:8]});
			cyc(40);
			chk(pin_analog_en, v);
			chk(pin_other_func_en, {21'h0, ~v});
			chk(conv_chan_connect & ~v, 33'h0);
		end
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		rd(12'h004, 33'h0ff);
		cyc(2);
		close_out();
	end
endmodule

bind aicc_top aicc_top_props u_props (.*);
